//--- include/dso_consts.vh
// Constants of the sync output control block: offsets, fields, resets, timing.
// Assumes byte-wide register ports with 12-bit byte addresses.
// How it works
// - Filter depth is a 4-bit low nibble, reset Ch; upper nibble reads zero.
// - Any write to the filter depth register pulses the speed filter reset.
// - Owner bit 5 picks latch unit 1 side; network-only write, reset 0.
// - Each latch unit interrupt goes to the side its owner bit selects.
// - Owner bit 4 picks latch unit 0; reads 1 while host owns system time.
// - Owner bit 0 picks sync unit side; only that side may write activation.
// - Writing activation bit 7 fires one debug pulse on each enabled output.
// - Bit 6 picks near-future window: 0 half width, 1 two to the 31 ns.
// - Bit 5 set makes an out-of-window start time start generation at once.
// - Bit 4 set extends a start time written as low 32 bits to 64.
// - Bit 3 set activates the sync unit after start time is written.
// - Bit 2 enables output b, bit 1 output a; both reset off.
// - Pulse length is 16 bits in 10 ns units, read-only from both sides.
// - Pulse length zero is acknowledge mode: output holds until host reads its status.
// - Pulse length resets from loaded configuration, else zero.
// - Status bit 2 records window check result at activation.
// - Status bits 1 and 0 show first b and a pulses still pending.
// - Output a status bit 0 mirrors output; in acknowledge mode a host read clears it.
// - Output b status bit 0 mirrors output; in acknowledge mode a host read clears it.
// - Multi-byte registers are little-endian, low byte at lowest address.
// - Start time takes writes; reads return time of next output a pulse.
// - Cycle time zero on output a gives a single pulse after activation.
`ifndef DSO_CONSTS_VH
`define DSO_CONSTS_VH

`define DSO_ADDR_W        12
`define DSO_OFF_FILT      12'h935
`define DSO_OFF_OWNER     12'h980
`define DSO_OFF_ACT       12'h981
`define DSO_OFF_PLEN      12'h982
`define DSO_OFF_ASTAT     12'h984
`define DSO_OFF_STAT_A    12'h98e
`define DSO_OFF_STAT_B    12'h98f
`define DSO_OFF_START     12'h990
`define DSO_OFF_CYC_A     12'h9a0
`define DSO_OFF_CYC_B     12'h9a4

`define DSO_FILT_RST      4'hc
`define DSO_PLEN_RST      16'h0000

`define DSO_OWN_SYNC      0
`define DSO_OWN_LATCH0    4
`define DSO_OWN_LATCH1    5

`define DSO_ACT_RUN       0
`define DSO_ACT_EN_A      1
`define DSO_ACT_EN_B      2
`define DSO_ACT_AUTO      3
`define DSO_ACT_EXT       4
`define DSO_ACT_PLAUS     5
`define DSO_ACT_NEAR      6
`define DSO_ACT_DBG       7

`define DSO_CLK_NS        24'h000032
`define DSO_PLEN_UNIT_NS  24'h00000a

`endif

//--- design/dso_time_cmp.v
// Compares system time with a scheduled 64-bit time.
// Assumes both times count nanoseconds on the same clock.
`timescale 1ns/1ps
module dso_time_cmp (
  // Times
  input  wire [63:0] now,
  input  wire [63:0] target,
  // Window select
  input  wire        win_short,
  // Results
  output wire        reached,
  output wire        outside
);
  wire [63:0] past_by = now - target;
  wire [63:0] ahead_by = target - now;

  assign reached = ~past_by[63];
  // Past times wrap to huge values and land outside
  assign outside = win_short ? (|ahead_by[63:31]) : ahead_by[63];
endmodule

//--- design/dso_pulse.v
// Shapes one sync output from a fire strobe.
// Assumes fire is a one-cycle pulse on the same clock.
`timescale 1ns/1ps
`include "dso_consts.vh"
module dso_pulse (
  // Clock and reset
  input  wire        ref_clk,
  input  wire        reset,
  // Control
  input  wire        fire,
  input  wire [15:0] plen,
  input  wire        ack_clr,
  // Output
  output reg         out_r
);
  localparam [23:0] STEP_NS = `DSO_CLK_NS;
  localparam [23:0] UNIT_NS = `DSO_PLEN_UNIT_NS;

  reg  [23:0] ns_r;
  wire [23:0] len_ns = plen * UNIT_NS;
  wire        ack_mode = (plen == 16'h0000);

  always @(posedge ref_clk) begin
    if (reset) begin
      out_r <= 1'b0;
      ns_r  <= 24'h000000;
    end else if (fire) begin
      // New event wins over a clear in the same cycle
      out_r <= 1'b1;
      ns_r  <= 24'h000000;
    end else if (out_r && ack_mode) begin
      if (ack_clr)
        out_r <= 1'b0;
    end else if (out_r) begin
      if (ns_r + STEP_NS >= len_ns)
        out_r <= 1'b0;
      ns_r <= ns_r + STEP_NS;
    end
  end
endmodule

//--- design/dso_top.v
// Sync output control and status registers with pulse scheduling.
// Assumes both register ports and system time run on ref_clk.
`timescale 1ns/1ps
`include "dso_consts.vh"
module dso_top (
  // Clock and reset
  input  wire        ref_clk,
  input  wire        reset,
  // Network side register port
  input  wire [11:0] net_addr,
  input  wire        net_wr,
  input  wire        net_rd,
  input  wire [7:0]  net_wdata,
  output reg  [7:0]  net_rdata_r,
  // Host port register port
  input  wire [11:0] host_addr,
  input  wire        host_wr,
  input  wire        host_rd,
  input  wire [7:0]  host_wdata,
  output reg  [7:0]  host_rdata_r,
  // System time
  input  wire [63:0] sys_time,
  input  wire        sys_time_host_ctl,
  // Loaded configuration
  input  wire        cfg_plen_valid,
  input  wire [15:0] cfg_plen,
  // Latch unit interrupts
  input  wire [1:0]  latch_irq,
  output reg  [1:0]  latch_irq_net_r,
  output reg  [1:0]  latch_irq_host_r,
  // Speed filter
  output reg  [3:0]  filt_depth_r,
  output reg         filt_reset_r,
  // Sync outputs
  output wire        sync_out_a,
  output wire        sync_out_b
);
  // Register state
  reg  [7:0]  owner_r;
  reg  [7:0]  act_r;
  reg  [15:0] plen_r;
  reg         plen_load_r;
  reg  [63:0] start_r;
  reg  [31:0] cyc_a_r;
  reg  [31:0] cyc_b_r;
  reg         plaus_r;
  reg         pend_a_r;
  reg         pend_b_r;
  reg         run_a_r;
  reg         arm_b_r;
  reg         auto_r;
  reg  [63:0] next_a_r;
  reg  [63:0] next_b_r;

  // Next values
  reg  [7:0]  owner_nxt;
  reg  [7:0]  act_nxt;
  reg  [3:0]  filt_nxt;
  reg         filt_rst_nxt;
  reg  [63:0] start_nxt;
  reg  [31:0] cyc_a_nxt;
  reg  [31:0] cyc_b_nxt;
  reg         auto_nxt;
  reg         act_ev;
  reg         dbg_ev;

  wire [7:0]  owner_eff;
  wire        reach_a;
  wire        reach_b;
  wire        out_start;
  wire [1:0]  fire;
  wire [1:0]  ack_clr;
  wire [1:0]  sync_q;
  wire [7:0]  astat;

  assign owner_eff = {owner_r[7:5],
                      owner_r[`DSO_OWN_LATCH0] | sys_time_host_ctl,
                      owner_r[3:0]};
  assign astat = {5'h00, plaus_r, pend_b_r, pend_a_r};

  // One register write from either side
  task do_write;
    input        is_host;
    input [11:0] a;
    input [7:0]  d;
    reg          may_sync;
    begin
      may_sync = (owner_r[`DSO_OWN_SYNC] == is_host);
      if (a == `DSO_OFF_FILT) begin
        filt_nxt     = d[3:0];
        filt_rst_nxt = 1'b1;
      end else if (a == `DSO_OFF_OWNER) begin
        if (!is_host)
          owner_nxt = d & 8'h31;
      end else if (a == `DSO_OFF_ACT) begin
        if (may_sync) begin
          act_nxt = {1'b0, d[6:0]};
          if (d[`DSO_ACT_RUN] && !act_r[`DSO_ACT_RUN])
            act_ev = 1'b1;
          if (d[`DSO_ACT_DBG])
            dbg_ev = 1'b1;
        end
      end else if (a[11:3] == `DSO_OFF_START >> 3) begin
        if (may_sync) begin
          start_nxt[a[2:0]*8 +: 8] = d;
          if (a[2:0] == 3'h3 && act_r[`DSO_ACT_EXT]) begin
            // Nearest future upper word for a 32-bit start time
            start_nxt[63:32] = sys_time[63:32] +
              {31'h00000000, start_nxt[31:0] < sys_time[31:0]};
            auto_nxt = act_r[`DSO_ACT_AUTO];
          end
          if (a[2:0] == 3'h7)
            auto_nxt = act_r[`DSO_ACT_AUTO];
        end
      end else if (a[11:2] == `DSO_OFF_CYC_A >> 2) begin
        if (may_sync)
          cyc_a_nxt[a[1:0]*8 +: 8] = d;
      end else if (a[11:2] == `DSO_OFF_CYC_B >> 2) begin
        if (may_sync)
          cyc_b_nxt[a[1:0]*8 +: 8] = d;
      end
    end
  endtask

  // Read mux, shared by both sides
  function [7:0] rd_byte;
    input [11:0] a;
    begin
      if (a == `DSO_OFF_FILT)
        rd_byte = {4'h0, filt_depth_r};
      else if (a == `DSO_OFF_OWNER)
        rd_byte = owner_eff;
      else if (a == `DSO_OFF_ACT)
        rd_byte = act_r;
      else if (a == `DSO_OFF_PLEN)
        rd_byte = plen_r[7:0];
      else if (a == `DSO_OFF_PLEN + 12'h001)
        rd_byte = plen_r[15:8];
      else if (a == `DSO_OFF_ASTAT)
        rd_byte = astat;
      else if (a == `DSO_OFF_STAT_A)
        rd_byte = {7'h00, sync_q[0]};
      else if (a == `DSO_OFF_STAT_B)
        rd_byte = {7'h00, sync_q[1]};
      else if (a[11:3] == `DSO_OFF_START >> 3)
        rd_byte = next_a_r[a[2:0]*8 +: 8];
      else if (a[11:2] == `DSO_OFF_CYC_A >> 2)
        rd_byte = cyc_a_r[a[1:0]*8 +: 8];
      else if (a[11:2] == `DSO_OFF_CYC_B >> 2)
        rd_byte = cyc_b_r[a[1:0]*8 +: 8];
      else
        rd_byte = 8'h00;
    end
  endfunction

  // Writes: host first so the network side wins a collision
  always @* begin
    owner_nxt    = owner_r;
    act_nxt      = act_r;
    filt_nxt     = filt_depth_r;
    filt_rst_nxt = 1'b0;
    start_nxt    = start_r;
    cyc_a_nxt    = cyc_a_r;
    cyc_b_nxt    = cyc_b_r;
    auto_nxt     = 1'b0;
    act_ev       = 1'b0;
    dbg_ev       = 1'b0;
    if (host_wr)
      do_write(1'b1, host_addr, host_wdata);
    if (net_wr)
      do_write(1'b0, net_addr, net_wdata);
    if (auto_r && !act_r[`DSO_ACT_RUN]) begin
      act_nxt[`DSO_ACT_RUN] = 1'b1;
      act_ev = 1'b1;
    end
  end

  // Window check against the written start time
  dso_time_cmp u_cmp_start (
    .now       (sys_time),
    .target    (start_r),
    .win_short (act_nxt[`DSO_ACT_NEAR]),
    .reached   (),
    .outside   (out_start)
  );

  dso_time_cmp u_cmp_a (
    .now       (sys_time),
    .target    (next_a_r),
    .win_short (act_r[`DSO_ACT_NEAR]),
    .reached   (reach_a),
    .outside   ()
  );

  dso_time_cmp u_cmp_b (
    .now       (sys_time),
    .target    (next_b_r),
    .win_short (act_r[`DSO_ACT_NEAR]),
    .reached   (reach_b),
    .outside   ()
  );

  wire go_a = run_a_r && act_r[`DSO_ACT_RUN] && reach_a && !act_ev;
  wire go_b = arm_b_r && act_r[`DSO_ACT_RUN] && reach_b && !act_ev;

  // Debug ping obeys the enables written with it
  assign fire[0] = (go_a && act_r[`DSO_ACT_EN_A]) ||
                   (dbg_ev && act_nxt[`DSO_ACT_EN_A]);
  assign fire[1] = (go_b && act_r[`DSO_ACT_EN_B]) ||
                   (dbg_ev && act_nxt[`DSO_ACT_EN_B]);

  // Register update and scheduling
  always @(posedge ref_clk) begin
    if (reset) begin
      owner_r      <= 8'h00;
      act_r        <= 8'h00;
      filt_depth_r <= `DSO_FILT_RST;
      filt_reset_r <= 1'b0;
      plen_r       <= `DSO_PLEN_RST;
      plen_load_r  <= 1'b1;
      start_r      <= 64'h0000000000000000;
      cyc_a_r      <= 32'h00000000;
      cyc_b_r      <= 32'h00000000;
      auto_r       <= 1'b0;
      plaus_r      <= 1'b0;
      pend_a_r     <= 1'b0;
      pend_b_r     <= 1'b0;
      run_a_r      <= 1'b0;
      arm_b_r      <= 1'b0;
      next_a_r     <= 64'h0000000000000000;
      next_b_r     <= 64'h0000000000000000;
    end else begin
      owner_r      <= owner_nxt;
      act_r        <= act_nxt;
      filt_depth_r <= filt_nxt;
      filt_reset_r <= filt_rst_nxt;
      start_r      <= start_nxt;
      cyc_a_r      <= cyc_a_nxt;
      cyc_b_r      <= cyc_b_nxt;
      auto_r       <= auto_nxt;
      plen_load_r  <= 1'b0;
      if (plen_load_r && cfg_plen_valid)
        plen_r <= cfg_plen;
      if (act_ev) begin
        plaus_r  <= out_start;
        pend_a_r <= act_nxt[`DSO_ACT_EN_A];
        pend_b_r <= act_nxt[`DSO_ACT_EN_B];
        run_a_r  <= 1'b1;
        arm_b_r  <= 1'b0;
        if (act_nxt[`DSO_ACT_PLAUS] && out_start)
          next_a_r <= sys_time;
        else
          next_a_r <= start_r;
      end else if (!act_nxt[`DSO_ACT_RUN]) begin
        run_a_r  <= 1'b0;
        arm_b_r  <= 1'b0;
        pend_a_r <= 1'b0;
        pend_b_r <= 1'b0;
        next_a_r <= start_nxt;
      end else begin
        if (go_a) begin
          pend_a_r <= 1'b0;
          arm_b_r  <= 1'b1;
          next_b_r <= next_a_r + {32'h00000000, cyc_b_r};
          if (cyc_a_r == 32'h00000000)
            run_a_r <= 1'b0;
          else
            next_a_r <= next_a_r + {32'h00000000, cyc_a_r};
        end
        if (go_b) begin
          pend_b_r <= 1'b0;
          arm_b_r  <= 1'b0;
        end
      end
    end
  end

  // Read data and latch interrupt routing
  always @(posedge ref_clk) begin
    if (reset) begin
      net_rdata_r      <= 8'h00;
      host_rdata_r     <= 8'h00;
      latch_irq_net_r  <= 2'b00;
      latch_irq_host_r <= 2'b00;
    end else begin
      net_rdata_r  <= net_rd ? rd_byte(net_addr) : 8'h00;
      host_rdata_r <= host_rd ? rd_byte(host_addr) : 8'h00;
      latch_irq_host_r <= latch_irq & owner_eff[5:4];
      latch_irq_net_r  <= latch_irq & ~owner_eff[5:4];
    end
  end

  assign ack_clr[0] = host_rd && (host_addr == `DSO_OFF_STAT_A);
  assign ack_clr[1] = host_rd && (host_addr == `DSO_OFF_STAT_B);

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_out
      dso_pulse u_pulse (
        .ref_clk (ref_clk),
        .reset   (reset),
        .fire    (fire[gi]),
        .plen    (plen_r),
        .ack_clr (ack_clr[gi]),
        .out_r   (sync_q[gi])
      );
    end
  endgenerate

  assign sync_out_a = sync_q[0];
  assign sync_out_b = sync_q[1];
endmodule

//--- bench/dso_chk.sv
// Checker of the sync output control block, bound to its top module.
// Assumes one clock, ref_clk, and a synchronous active-high reset.
`timescale 1ns/1ps
module dso_chk (
  // Clock and reset
  input wire        ref_clk,
  input wire        reset,
  // Register ports
  input wire [11:0] net_addr,
  input wire        net_wr,
  input wire [7:0]  net_wdata,
  input wire [11:0] host_addr,
  input wire        host_wr,
  input wire        host_rd,
  input wire [7:0]  host_rdata_r,
  // Time owner and loaded configuration
  input wire        sys_time_host_ctl,
  input wire        cfg_plen_valid,
  input wire [15:0] cfg_plen,
  // Latch interrupts
  input wire [1:0]  latch_irq,
  input wire [1:0]  latch_irq_net_r,
  input wire [1:0]  latch_irq_host_r,
  // Filter and sync outputs
  input wire [3:0]  filt_depth_r,
  input wire        filt_reset_r,
  input wire        sync_out_a,
  input wire        sync_out_b
);
  reg  [7:0]  own_r;
  reg  [15:0] plen_r;
  reg         rst_d_r;
  reg  [19:0] cnt_r;
  wire [19:0] lim = ({4'h0, plen_r} * 20'ha + 20'h31) / 20'h32;
  wire [1:0]  eff = {own_r[5], own_r[4] | sys_time_host_ctl};
  wire        rd_sa = host_rd && host_addr == 12'h98e;

  // Shadow owner, loaded pulse length, high time of output a
  always @(posedge ref_clk) begin
    rst_d_r <= reset;
    cnt_r <= sync_out_a ? cnt_r + 20'h1 : 20'h0;
    if (reset) begin
      own_r <= 8'h0;
      plen_r <= 16'h0;
      cnt_r <= 20'h0;
    end else begin
      if (net_wr && net_addr == 12'h980)
        own_r <= net_wdata & 8'h31;
      if (rst_d_r)
        plen_r <= cfg_plen_valid ? cfg_plen : 16'h0;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence filt_wr_s;
    (net_wr && net_addr == 12'h935) || (host_wr && host_addr == 12'h935);
  endsequence
  sequence dbg_wr_s;
    net_wr && net_addr == 12'h981 && net_wdata[7] && net_wdata[1] && !own_r[0];
  endsequence

  filt_reset_a: assert property (filt_wr_s |=> filt_reset_r)
    else $error("filter reset pulse missing");
  filt_value_a: assert property ((net_wr && net_addr == 12'h935)
    |=> filt_depth_r == $past(net_wdata[3:0])) else $error("bad depth");
  owner_read_a: assert property ((host_rd && host_addr == 12'h980)
    |=> host_rdata_r == ($past(own_r) | {3'h0, $past(sys_time_host_ctl),
    4'h0})) else $error("bad owner read");
  irq_route_a: assert property (!$past(reset) |->
    latch_irq_host_r == ($past(latch_irq) & $past(eff)) &&
    latch_irq_net_r == ($past(latch_irq) & ~$past(eff)))
    else $error("bad latch interrupt routing");
  plen_read_a: assert property ((host_rd && host_addr[11:1] == 11'h4c1)
    |=> host_rdata_r == ($past(host_addr[0]) ? plen_r[15:8] : plen_r[7:0]))
    else $error("bad pulse length read");
  debug_fire_a: assert property (dbg_wr_s |-> ##[1:4] sync_out_a)
    else $error("debug pulse missing");
  ack_hold_a: assert property ((plen_r == 16'h0 && sync_out_a && !rd_sa
    && !$past(rd_sa)) |=> sync_out_a) else $error("ack output dropped");
  pulse_len_a: assert property (($fell(sync_out_a) && plen_r != 16'h0)
    |-> cnt_r == lim) else $error("bad pulse width");
  stat_a_a: assert property (rd_sa
    |=> host_rdata_r == {7'h0, $past(sync_out_a)}) else $error("bad a state");
  stat_b_a: assert property ((host_rd && host_addr == 12'h98f)
    |=> host_rdata_r == {7'h0, $past(sync_out_b)}) else $error("bad b state");
endmodule

bind dso_top dso_chk dso_chk_i (
  .ref_clk(ref_clk), .reset(reset), .net_addr(net_addr), .net_wr(net_wr),
  .net_wdata(net_wdata), .host_addr(host_addr), .host_wr(host_wr),
  .host_rd(host_rd), .host_rdata_r(host_rdata_r),
  .sys_time_host_ctl(sys_time_host_ctl), .cfg_plen_valid(cfg_plen_valid),
  .cfg_plen(cfg_plen), .latch_irq(latch_irq),
  .latch_irq_net_r(latch_irq_net_r), .latch_irq_host_r(latch_irq_host_r),
  .filt_depth_r(filt_depth_r), .filt_reset_r(filt_reset_r),
  .sync_out_a(sync_out_a), .sync_out_b(sync_out_b));

//--- bench/dso_ctl_model.sv
// Partner: network master and host controller on the register ports.
// Assumes ref_clk is the block clock; requests change at falling edges.
`timescale 1ns/1ps
module dso_ctl_model (
  // Clock
  input  wire         ref_clk,
  // Network side
  output logic [11:0] net_addr,
  output logic        net_wr,
  output logic        net_rd,
  output logic [7:0]  net_wdata,
  input  wire  [7:0]  net_rdata_r,
  // Host port
  output logic [11:0] host_addr,
  output logic        host_wr,
  output logic        host_rd,
  output logic [7:0]  host_wdata,
  input  wire  [7:0]  host_rdata_r,
  // System time in ns
  output logic [63:0] sys_time
);
  initial begin
    {net_addr, net_wdata, net_wr, net_rd} = 22'h0;
    {host_addr, host_wdata, host_wr, host_rd} = 22'h0;
    sys_time = 64'h0;
  end

  // Time advances one clock period per cycle
  always @(posedge ref_clk)
    sys_time <= sys_time + 64'h32;

  // One byte transfer, strobe held over one rising edge
  task automatic xfer(input logic h, input logic w, input logic [11:0] a,
                      input logic [7:0] d, output logic [7:0] q);
    @(negedge ref_clk);
    if (h) begin
      {host_addr, host_wdata, host_wr, host_rd} = {a, d, w, !w};
    end else begin
      {net_addr, net_wdata, net_wr, net_rd} = {a, d, w, !w};
    end
    @(negedge ref_clk);
    q = h ? host_rdata_r : net_rdata_r;
    {net_wr, net_rd, host_wr, host_rd} = 4'h0;
    // Released lines do not keep the last value
    net_addr = ~net_addr;
    net_wdata = ~net_wdata;
    host_addr = ~host_addr;
    host_wdata = ~host_wdata;
  endtask
endmodule

//--- bench/tb_dc_sync_out_control.sv
// Testbench of the sync output control block with its port partner.
// Assumes design files and the checker are compiled before it.
`timescale 1ns/1ps
module tb_dc_sync_out_control;
  logic        ref_clk = 1'b0;
  logic        reset = 1'b1;
  logic        sys_time_host_ctl = 1'b0;
  logic        cfg_plen_valid = 1'b1;
  logic [15:0] cfg_plen = 16'h0003;
  logic [1:0]  latch_irq = 2'h0;
  logic [63:0] st;
  wire  [11:0] net_addr, host_addr;
  wire         net_wr, net_rd, host_wr, host_rd;
  wire  [7:0]  net_wdata, host_wdata, net_rdata_r, host_rdata_r;
  wire  [63:0] sys_time;
  wire  [1:0]  latch_irq_net_r, latch_irq_host_r;
  wire  [3:0]  filt_depth_r;
  wire         filt_reset_r, sync_out_a, sync_out_b;
  int          miscompares = 0;
  int          total_checks = 0;
  int          cyc = 0;
  int          n;

  always #25 ref_clk = ~ref_clk;

  dso_ctl_model dso_ctl_model_i (.ref_clk(ref_clk), .net_addr(net_addr),
    .net_wr(net_wr), .net_rd(net_rd), .net_wdata(net_wdata),
    .net_rdata_r(net_rdata_r), .host_addr(host_addr), .host_wr(host_wr),
    .host_rd(host_rd), .host_wdata(host_wdata),
    .host_rdata_r(host_rdata_r), .sys_time(sys_time));
  dso_top dso_top_i (.ref_clk(ref_clk), .reset(reset), .net_addr(net_addr),
    .net_wr(net_wr), .net_rd(net_rd), .net_wdata(net_wdata),
    .net_rdata_r(net_rdata_r), .host_addr(host_addr), .host_wr(host_wr),
    .host_rd(host_rd), .host_wdata(host_wdata),
    .host_rdata_r(host_rdata_r), .sys_time(sys_time),
    .sys_time_host_ctl(sys_time_host_ctl), .cfg_plen_valid(cfg_plen_valid),
    .cfg_plen(cfg_plen), .latch_irq(latch_irq),
    .latch_irq_net_r(latch_irq_net_r), .latch_irq_host_r(latch_irq_host_r),
    .filt_depth_r(filt_depth_r), .filt_reset_r(filt_reset_r),
    .sync_out_a(sync_out_a), .sync_out_b(sync_out_b));

  task automatic summarize;
    $display("checks=%0d miscompares=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      summarize();
    end
  end

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic h, input logic [11:0] a, input logic [7:0] d);
    logic [7:0] q;
    dso_ctl_model_i.xfer(h, 1'b1, a, d, q);
  endtask
  task automatic rd(input logic h, input logic [11:0] a, input logic [7:0] e);
    logic [7:0] q;
    dso_ctl_model_i.xfer(h, 1'b0, a, 8'h0, q);
    check(q, e);
  endtask
  task automatic wr_n(input logic [11:0] a, input int k, input logic [63:0] v);
    for (int i = 0; i < k; i++)
      wr(1'b0, a + 12'(i), v[8*i +: 8]);
  endtask
  task automatic wait_out(input logic b, input int lim);
    for (int i = 0; i < lim && (b ? sync_out_b : sync_out_a) !== 1'b1; i++)
      @(negedge ref_clk);
    check(b ? sync_out_b : sync_out_a, 1'b1);
  endtask
  task automatic do_reset(input logic v, input logic [15:0] len);
    @(negedge ref_clk);
    reset = 1'b1;
    cfg_plen_valid = v;
    cfg_plen = len;
    repeat (5) @(negedge ref_clk);
    reset = 1'b0;
  endtask

  task automatic sc_regs;
    check(filt_depth_r, 4'hc);
    rd(1'b0, 12'h935, 8'h0c);
    wr(1'b0, 12'h982, 8'hff);
    rd(1'b1, 12'h982, 8'h03);
    rd(1'b1, 12'h983, 8'h00);
    rd(1'b0, 12'h984, 8'h00);
    rd(1'b1, 12'h7ff, 8'h00);
    wr(1'b0, 12'h935, 8'hf5);
    check(filt_reset_r, 1'b1);
    rd(1'b1, 12'h935, 8'h05);
  endtask
  task automatic sc_owner;
    wr(1'b1, 12'h980, 8'h31);
    rd(1'b0, 12'h980, 8'h00);
    wr(1'b0, 12'h980, 8'h20);
    sys_time_host_ctl = 1'b1;
    rd(1'b1, 12'h980, 8'h30);
    sys_time_host_ctl = 1'b0;
    latch_irq = 2'h3;
    repeat (2) @(negedge ref_clk);
    check({latch_irq_host_r, latch_irq_net_r}, 4'b1001);
    latch_irq = 2'h0;
    wr(1'b0, 12'h980, 8'h01);
    wr(1'b0, 12'h981, 8'h06);
    rd(1'b1, 12'h981, 8'h00);
    wr(1'b1, 12'h981, 8'h02);
    rd(1'b0, 12'h981, 8'h02);
    wr(1'b0, 12'h980, 8'h00);
  endtask
  task automatic sc_pulses;
    wr(1'b0, 12'h981, 8'h82);
    wait_out(1'b0, 4);
    check(sync_out_b, 1'b0);
    rd(1'b0, 12'h981, 8'h02);
    wr_n(12'h9a0, 4, 64'h0);
    st = sys_time + 64'h1000;
    wr_n(12'h990, 8, st);
    rd(1'b0, 12'h990, st[7:0]);
    wr(1'b0, 12'h981, 8'h03);
    rd(1'b0, 12'h984, 8'h01);
    wait_out(1'b0, 150);
    rd(1'b0, 12'h984, 8'h00);
    n = 0;
    repeat (150) begin
      @(negedge ref_clk);
      n += sync_out_a;
    end
    check(n, 0);
    wr(1'b0, 12'h981, 8'h00);
    wr_n(12'h990, 8, sys_time + 64'h100000000);
    wr(1'b0, 12'h981, 8'h63);
    wait_out(1'b0, 6);
    rd(1'b0, 12'h984, 8'h04);
    wr(1'b0, 12'h981, 8'h1a);
    wr_n(12'h990, 4, sys_time + 64'h1000);
    repeat (3) @(negedge ref_clk);
    rd(1'b0, 12'h994, 8'h00);
    rd(1'b0, 12'h981, 8'h1b);
    wait_out(1'b0, 150);
    wr(1'b0, 12'h981, 8'h00);
  endtask
  task automatic sc_ack;
    do_reset(1'b0, 16'h0005);
    rd(1'b1, 12'h982, 8'h00);
    wr(1'b0, 12'h981, 8'h86);
    wait_out(1'b1, 4);
    repeat (20) @(negedge ref_clk);
    check(sync_out_a, 1'b1);
    rd(1'b0, 12'h98e, 8'h01);
    check(sync_out_a, 1'b1);
    rd(1'b1, 12'h98e, 8'h01);
    @(negedge ref_clk);
    check({sync_out_b, sync_out_a}, 2'b10);
    rd(1'b1, 12'h98f, 8'h01);
    @(negedge ref_clk);
    check(sync_out_b, 1'b0);
  endtask

  initial begin
    do_reset(1'b1, 16'h0003);
    sc_regs();
    sc_owner();
    sc_pulses();
    sc_ack();
    summarize();
  end
endmodule
